/* File: core/sdsc_pkg.sv */
// constants and types shared by the stepper drive state control core
// assumes a 20 MHz mclk and a word-level holding-register access port
package sdsc_pkg;
    localparam int unsigned SDSC_MCLK_HZ       = 20_000_000;
    localparam int unsigned SDSC_HV_SETTLE_MS  = 500;
    localparam int unsigned SDSC_HV_SETTLE_CYC = SDSC_MCLK_HZ / 1000 * SDSC_HV_SETTLE_MS;

    // holding-register entity addresses
    localparam logic [15:0] SDSC_A_CTRL   = 16'h03E8;
    localparam logic [15:0] SDSC_A_STAT   = 16'h03E9;
    localparam logic [15:0] SDSC_A_TGT    = 16'h03EA;
    localparam logic [15:0] SDSC_A_POS    = 16'h03EC;
    localparam logic [15:0] SDSC_A_CLRCFG = 16'h045A;
    localparam logic [15:0] SDSC_A_ORDER  = 16'h0465;

    // function codes and exception codes
    localparam logic [7:0] SDSC_FC_RD_HOLD = 8'h03;
    localparam logic [7:0] SDSC_FC_RD_INP  = 8'h04;
    localparam logic [7:0] SDSC_FC_WR_ONE  = 8'h06;
    localparam logic [7:0] SDSC_FC_WR_MULT = 8'h10;
    localparam logic [7:0] SDSC_EX_FUNC    = 8'h01;
    localparam logic [7:0] SDSC_EX_ADDR    = 8'h02;

    // control word bits
    localparam int SDSC_CW_SWON  = 0;
    localparam int SDSC_CW_ENV   = 1;
    localparam int SDSC_CW_QSN   = 2;
    localparam int SDSC_CW_ENOP  = 3;
    localparam int SDSC_CW_FRST  = 7;
    // status word bits
    localparam int SDSC_SW_RTSO  = 0;
    localparam int SDSC_SW_SWON  = 1;
    localparam int SDSC_SW_OPEN  = 2;
    localparam int SDSC_SW_FAULT = 3;
    localparam int SDSC_SW_VOLT  = 4;
    localparam int SDSC_SW_QSN   = 5;
    localparam int SDSC_SW_SOD   = 6;
    localparam int SDSC_SW_TREA  = 10;

    localparam logic [15:0] SDSC_CTRL_RST  = 16'h0000;
    localparam logic [15:0] SDSC_CLRCFG_RST = 16'h0000;
    localparam logic        SDSC_ORDER_RST = 1'b0; // 0 little-endian, 1 big-endian

    typedef enum logic [2:0] {
        SDSC_SOD   = 3'b000,
        SDSC_RTSO  = 3'b001,
        SDSC_SWON  = 3'b011,
        SDSC_OPEN  = 3'b010,
        SDSC_QSA   = 3'b110,
        SDSC_FAULT = 3'b100
    } sdsc_state_t;

    typedef enum logic [2:0] {
        SDSC_C_NONE, SDSC_C_SHUT, SDSC_C_DISV, SDSC_C_QSTOP,
        SDSC_C_DISOP, SDSC_C_ENOP, SDSC_C_FRST
    } sdsc_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sdsc_req_t;

    typedef struct packed {
        logic        valid;
        logic        exc;
        logic [7:0]  exc_code;
        logic [15:0] rdata;
    } sdsc_rsp_t;
endpackage

/* File: core/sdsc_core.sv */
// stepper drive state control core: holding registers, word pairing, power-state machine
// assumes one word request per cycle from the protocol front end, pins are asynchronous
// Summary of operation
// - every transfer moves one 16-bit word
// - little-endian order: high word first
// - big-endian order: low word first
// - word order selectable, little-endian after reset
// - 32-bit register commits on second word
// - all registers sit in holding section
// - read codes 0x03 and 0x04 accepted
// - write codes 0x06 and 0x10 accepted
// - logic power-up enters switch on disabled
// - switch on needs power settled 500 ms
// - enable operation in switched on turns winding current on
// - first enable clears position if configured
// - disable operation returns to switched on
// - shutdown in switched on gives ready
// - shutdown in operation enabled gives ready
// - disable voltage in operation enabled disables
// - switched on: disable voltage/quick stop disables
// - quick stop keeps current, target bit shows stop
// - quick stop left by disable voltage or enable operation
// - internal fault enters fault, current off
// - fault reset leaves fault once cleared
// - control word bit layout
// - status word bit layout
// - enable operation resumes from quick stop
module sdsc_core
    import sdsc_pkg::*;
#(
    parameter int unsigned HV_SETTLE_CYC = SDSC_HV_SETTLE_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire sdsc_req_t   mb_req,
    output sdsc_rsp_t        mb_rsp,
    input  wire logic        hv_present_pin,
    input  wire logic        fault_pin,
    input  wire logic        motion_stopped,
    input  wire logic        pos_step,
    input  wire logic        pos_dir,
    output logic             winding_on,
    output logic [31:0]      target_pos,
    output logic [15:0]      drive_status
);
    typedef struct packed {
        logic [1:0]  hv_sync;
        logic [1:0]  flt_sync;
        sdsc_state_t st;
        logic [15:0] ctrl;
        logic        order_be;
        logic [15:0] clr_cfg;
        logic        first_done;
        logic [31:0] pos;
        logic [31:0] tgt;
        logic [15:0] pend;
        logic [15:0] rd_hold;
        logic [23:0] hv_cnt;
        sdsc_rsp_t   rsp;
    } sdsc_regs_t;

    sdsc_regs_t s_r;
    sdsc_regs_t s_nxt;

    // true when this word of a pair is the high word
    function automatic logic half_is_msw(input logic second, input logic be);
        return ~(second ^ be);
    endfunction

    function automatic logic [15:0] pick_half(input logic [31:0] v, input logic msw);
        return msw ? v[31:16] : v[15:0];
    endfunction

    function automatic sdsc_cmd_t decode_cmd(input logic [15:0] cw, input logic [15:0] old);
        if (cw[SDSC_CW_FRST])
            return old[SDSC_CW_FRST] ? SDSC_C_NONE : SDSC_C_FRST;
        if (!cw[SDSC_CW_ENV])
            return SDSC_C_DISV;
        if (!cw[SDSC_CW_QSN])
            return SDSC_C_QSTOP;
        if (!cw[SDSC_CW_SWON])
            return SDSC_C_SHUT;
        return cw[SDSC_CW_ENOP] ? SDSC_C_ENOP : SDSC_C_DISOP;
    endfunction

    logic        hv_ok;
    logic        flt_ok;
    logic        hv_ready;
    logic        is_rd;
    logic        is_wr;
    logic        cw_fire;
    logic        pair_first;
    logic        pair_second;
    logic [15:0] base;
    sdsc_cmd_t   cmd;
    logic [15:0] stat;

    // only the second synchroniser stage is read
    assign hv_ok    = s_r.hv_sync[1];
    assign flt_ok   = s_r.flt_sync[1];
    assign hv_ready = 32'(s_r.hv_cnt) >= HV_SETTLE_CYC;
    assign is_rd    = mb_req.valid &&
                      (mb_req.func == SDSC_FC_RD_HOLD || mb_req.func == SDSC_FC_RD_INP);
    assign is_wr    = mb_req.valid &&
                      (mb_req.func == SDSC_FC_WR_ONE || mb_req.func == SDSC_FC_WR_MULT);
    assign cw_fire  = is_wr && mb_req.addr == SDSC_A_CTRL;
    assign cmd      = cw_fire ? decode_cmd(mb_req.wdata, s_r.ctrl) : SDSC_C_NONE;
    assign base     = {mb_req.addr[15:1], 1'b0};
    assign pair_first  = (base == SDSC_A_TGT || base == SDSC_A_POS) && !mb_req.addr[0];
    assign pair_second = (base == SDSC_A_TGT || base == SDSC_A_POS) && mb_req.addr[0];

    always_comb begin
        stat = '0;
        unique case (s_r.st)
            SDSC_SOD:   stat[SDSC_SW_SOD] = 1'b1;
            SDSC_RTSO:  stat[SDSC_SW_RTSO] = 1'b1;
            SDSC_SWON:  stat[SDSC_SW_SWON:SDSC_SW_RTSO] = 2'h3;
            SDSC_OPEN,
            SDSC_QSA:   stat[SDSC_SW_OPEN:SDSC_SW_RTSO] = 3'h7;
            SDSC_FAULT: stat[SDSC_SW_FAULT] = 1'b1;
            default:    stat[SDSC_SW_FAULT] = 1'b1;
        endcase
        stat[SDSC_SW_QSN]  = s_r.st != SDSC_QSA;
        stat[SDSC_SW_VOLT] = hv_ok;
        stat[SDSC_SW_TREA] = motion_stopped;
    end

    always_comb begin
        s_nxt          = s_r;
        s_nxt.rsp      = '0;
        s_nxt.hv_sync  = {s_r.hv_sync[0], hv_present_pin};
        s_nxt.flt_sync = {s_r.flt_sync[0], fault_pin};
        if (!hv_ok)
            s_nxt.hv_cnt = '0;
        else if (!hv_ready)
            s_nxt.hv_cnt = s_r.hv_cnt + 24'h000001;
        if (pos_step)
            s_nxt.pos = pos_dir ? s_r.pos - 32'h00000001 : s_r.pos + 32'h00000001;

        // one word per access, answer one cycle later
        if (mb_req.valid) begin
            s_nxt.rsp.valid = 1'b1;
            if (is_rd) begin
                unique case (1'b1)
                    mb_req.addr == SDSC_A_CTRL:   s_nxt.rsp.rdata = s_r.ctrl;
                    mb_req.addr == SDSC_A_STAT:   s_nxt.rsp.rdata = stat;
                    mb_req.addr == SDSC_A_CLRCFG: s_nxt.rsp.rdata = s_r.clr_cfg;
                    mb_req.addr == SDSC_A_ORDER:  s_nxt.rsp.rdata = {15'h0000, s_r.order_be};
                    pair_first: begin
                        // snapshot the other half so a pair reads coherently
                        s_nxt.rsp.rdata = pick_half(base == SDSC_A_POS ? s_r.pos : s_r.tgt,
                                                    half_is_msw(1'b0, s_r.order_be));
                        s_nxt.rd_hold   = pick_half(base == SDSC_A_POS ? s_r.pos : s_r.tgt,
                                                    half_is_msw(1'b1, s_r.order_be));
                    end
                    pair_second:  s_nxt.rsp.rdata = s_r.rd_hold;
                    default: begin
                        s_nxt.rsp.exc      = 1'b1;
                        s_nxt.rsp.exc_code = SDSC_EX_ADDR;
                    end
                endcase
            end else if (is_wr) begin
                unique case (1'b1)
                    mb_req.addr == SDSC_A_CTRL:   s_nxt.ctrl = mb_req.wdata;
                    mb_req.addr == SDSC_A_CLRCFG: s_nxt.clr_cfg = mb_req.wdata;
                    mb_req.addr == SDSC_A_ORDER:  s_nxt.order_be = mb_req.wdata[0];
                    pair_first && base == SDSC_A_TGT: s_nxt.pend = mb_req.wdata;
                    pair_second && base == SDSC_A_TGT: begin
                        // unfinished pairs commit whatever first word is pending
                        if (half_is_msw(1'b1, s_r.order_be))
                            s_nxt.tgt = {mb_req.wdata, s_r.pend};
                        else
                            s_nxt.tgt = {s_r.pend, mb_req.wdata};
                    end
                    default: begin
                        s_nxt.rsp.exc      = 1'b1;
                        s_nxt.rsp.exc_code = SDSC_EX_ADDR;
                    end
                endcase
            end else begin
                s_nxt.rsp.exc      = 1'b1;
                s_nxt.rsp.exc_code = SDSC_EX_FUNC;
            end
        end

        // commands not listed per state fall through unchanged
        unique case (s_r.st)
            SDSC_SOD:
                if (cmd == SDSC_C_SHUT)
                    s_nxt.st = SDSC_RTSO;
            SDSC_RTSO:
                if ((cmd == SDSC_C_DISOP || cmd == SDSC_C_ENOP) && hv_ready)
                    s_nxt.st = SDSC_SWON;
                else if (cmd == SDSC_C_DISV || cmd == SDSC_C_QSTOP)
                    s_nxt.st = SDSC_SOD;
            SDSC_SWON:
                if (cmd == SDSC_C_ENOP) begin
                    s_nxt.st         = SDSC_OPEN;
                    s_nxt.first_done = 1'b1;
                    if (!s_r.first_done && s_r.clr_cfg == 16'h0001)
                        s_nxt.pos = '0;
                end else if (cmd == SDSC_C_SHUT)
                    s_nxt.st = SDSC_RTSO;
                else if (cmd == SDSC_C_DISV || cmd == SDSC_C_QSTOP)
                    s_nxt.st = SDSC_SOD;
            SDSC_OPEN:
                unique case (cmd)
                    SDSC_C_DISOP: s_nxt.st = SDSC_SWON;
                    SDSC_C_SHUT:  s_nxt.st = SDSC_RTSO;
                    SDSC_C_DISV:  s_nxt.st = SDSC_SOD;
                    SDSC_C_QSTOP: s_nxt.st = SDSC_QSA;
                    default:      s_nxt.st = SDSC_OPEN;
                endcase
            SDSC_QSA:
                if (cmd == SDSC_C_DISV)
                    s_nxt.st = SDSC_SOD;
                else if (cmd == SDSC_C_ENOP)
                    s_nxt.st = SDSC_OPEN;
            SDSC_FAULT:
                if (cmd == SDSC_C_FRST && !flt_ok)
                    s_nxt.st = SDSC_SOD;
            default:
                s_nxt.st = SDSC_FAULT;
        endcase
        if (flt_ok)
            s_nxt.st = SDSC_FAULT;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r          <= '0;
            s_r.st       <= SDSC_SOD;
            s_r.ctrl     <= SDSC_CTRL_RST;
            s_r.clr_cfg  <= SDSC_CLRCFG_RST;
            s_r.order_be <= SDSC_ORDER_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mb_rsp       = s_r.rsp;
    assign winding_on   = s_r.st == SDSC_OPEN || s_r.st == SDSC_QSA;
    assign target_pos   = s_r.tgt;
    assign drive_status = stat;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_power_up_state: assert property ($rose(rst_n) |-> s_r.st == SDSC_SOD && !s_r.order_be)
        else $error("not in switch on disabled after reset");
    a_fault_entry: assert property (flt_ok |=> s_r.st == SDSC_FAULT && !winding_on)
        else $error("fault did not stop drive");
    // only switch-on commands are gated; disable voltage and quick stop still leave
    a_switch_on_gate: assert property (s_r.st == SDSC_RTSO && !hv_ready && !flt_ok
                                       && (cmd == SDSC_C_DISOP || cmd == SDSC_C_ENOP)
                                       |=> s_r.st == SDSC_RTSO)
        else $error("switched on without settled power");
    a_enable_current: assert property (s_r.st == SDSC_SWON && cmd == SDSC_C_ENOP
                                       && !flt_ok |=> winding_on && stat[SDSC_SW_OPEN])
        else $error("enable operation did not turn current on");
    a_pair_hold: assert property (is_wr && pair_first |=> $stable(target_pos))
        else $error("target changed on first word");
    a_qs_sticky: assert property (s_r.st == SDSC_QSA && cmd != SDSC_C_DISV
                                  && cmd != SDSC_C_ENOP && !flt_ok
                                  |=> s_r.st == SDSC_QSA && winding_on)
        else $error("quick stop left without command");
    // switch on disabled accepts shutdown only, so every other command must be ignored
    a_invalid_cmd: assert property (cw_fire && !flt_ok && (cmd == SDSC_C_NONE
                                    || s_r.st == SDSC_SOD && cmd != SDSC_C_SHUT)
                                    |=> $stable(s_r.st) && $stable(winding_on))
        else $error("ignored command changed state");
    a_status_map: assert property (stat[SDSC_SW_SOD] == (s_r.st == SDSC_SOD)
                                   && stat[SDSC_SW_QSN] == (s_r.st != SDSC_QSA))
        else $error("status word mismatch");
    a_resp_timing: assert property (mb_req.valid |=> mb_rsp.valid
                                    && (($past(is_rd) || $past(is_wr))
                                        == !(mb_rsp.exc && mb_rsp.exc_code == SDSC_EX_FUNC)))
        else $error("request not answered next cycle");
endmodule

/* File: dv/sdsc_master_model.sv */
// word-level register master in place of the network front end
// assumes the core answers one cycle after each taken request
module sdsc_master_model
    import sdsc_pkg::*;
(
    input  wire logic      mclk,
    input  wire sdsc_rsp_t rsp,
    output sdsc_req_t      req
);
    timeunit 1ns;
    timeprecision 1ns;

    initial req = '0;

    // one word per request, zero-based entity address
    task automatic xfer(input logic [7:0] f, input logic [15:0] a,
                        input logic [15:0] d, output sdsc_rsp_t r);
        @(negedge mclk);
        req <= '{valid: 1'b1, func: f, addr: a, wdata: d};
        @(negedge mclk);
        r = rsp;
        // idle fields inverted so a stale value is never mistaken for a live one
        req <= '{valid: 1'b0, func: ~f, addr: ~a, wdata: ~d};
    endtask
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the stepper drive state control core
// assumes a shortened power settle count and a master model on the register port
module testbench
    import sdsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s expected %0h seen %0h", n, e, g); end end

    logic        mclk;
    logic        rst_n;
    logic        hv_pin;
    logic        flt_pin;
    logic        mstop;
    logic        step;
    logic        dir;
    logic        won;
    logic [31:0] tpos;
    logic [15:0] stat;
    sdsc_req_t   req;
    sdsc_rsp_t   rsp;
    sdsc_rsp_t   r;
    int          fail_count = 0;
    int          cmp_count = 0;

    sdsc_core #(.HV_SETTLE_CYC(20)) uut (
        .mclk(mclk), .rst_n(rst_n), .mb_req(req), .mb_rsp(rsp),
        .hv_present_pin(hv_pin), .fault_pin(flt_pin), .motion_stopped(mstop),
        .pos_step(step), .pos_dir(dir), .winding_on(won), .target_pos(tpos),
        .drive_status(stat));

    sdsc_master_model mm (.mclk(mclk), .rsp(rsp), .req(req));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
        mm.xfer(f, a, d, r);
        `CHK("rsp_valid", 1'b1, r.valid)
    endtask

    task automatic cw(input logic [15:0] d);
        acc(SDSC_FC_WR_ONE, SDSC_A_CTRL, d);
    endtask

    task automatic st(input logic [7:0] e, input logic w);
        `CHK("status", e, stat[7:0] & 8'h6F)
        `CHK("winding", w, won)
    endtask

    task automatic t_reset();
        `CHK("status_rst", 16'h0460, stat)
        `CHK("winding_rst", 1'b0, won)
        acc(SDSC_FC_RD_HOLD, SDSC_A_ORDER, 16'h0000);
        `CHK("order_rst", 16'h0000, r.rdata)
        acc(SDSC_FC_RD_HOLD, SDSC_A_STAT, 16'h0000);
        `CHK("status_rd", 16'h0460, r.rdata)
        $display("done t_reset");
    endtask

    task automatic t_pairs();
        acc(SDSC_FC_WR_MULT, SDSC_A_TGT, 16'h1234);
        `CHK("tgt_half", 32'h0000_0000, tpos)
        acc(SDSC_FC_WR_MULT, SDSC_A_TGT | 16'h0001, 16'h5678);
        `CHK("tgt_le", 32'h1234_5678, tpos)
        acc(SDSC_FC_WR_ONE, SDSC_A_ORDER, 16'h0001);
        acc(SDSC_FC_WR_MULT, SDSC_A_TGT, 16'hAAAA);
        acc(SDSC_FC_WR_MULT, SDSC_A_TGT | 16'h0001, 16'h5555);
        `CHK("tgt_be", 32'h5555_AAAA, tpos)
        acc(SDSC_FC_RD_HOLD, SDSC_A_TGT, 16'h0000);
        `CHK("tgt_be_rd", 16'hAAAA, r.rdata)
        acc(SDSC_FC_WR_ONE, SDSC_A_ORDER, 16'h0000);
        $display("done t_pairs");
    endtask

    task automatic t_codes();
        acc(SDSC_FC_RD_INP, SDSC_A_STAT, 16'h0000);
        `CHK("rd_inp", 1'b0, r.exc)
        acc(8'h07, SDSC_A_STAT, 16'h0000);
        `CHK("bad_func", SDSC_EX_FUNC, r.exc_code)
        acc(SDSC_FC_WR_ONE, SDSC_A_STAT, 16'hFFFF);
        `CHK("wr_ro", SDSC_EX_ADDR, r.exc_code)
        acc(SDSC_FC_RD_HOLD, 16'h0100, 16'h0000);
        `CHK("unmapped", SDSC_EX_ADDR, r.exc_code)
        acc(SDSC_FC_WR_MULT, SDSC_A_CLRCFG, 16'h0001);
        acc(SDSC_FC_RD_HOLD, SDSC_A_CLRCFG, 16'h0000);
        `CHK("clrcfg", 16'h0001, r.rdata)
        $display("done t_codes");
    endtask

    task automatic t_states();
        @(negedge mclk) step = 1'b1;
        repeat (5) @(negedge mclk);
        // two counts down as well, so both directions reach the position register
        dir = 1'b1;
        repeat (2) @(negedge mclk);
        step = 1'b0;
        dir = 1'b0;
        acc(SDSC_FC_RD_HOLD, SDSC_A_POS, 16'h0000);
        acc(SDSC_FC_RD_HOLD, SDSC_A_POS | 16'h0001, 16'h0000);
        `CHK("pos_pre", 16'h0003, r.rdata)
        cw(16'h0006); st(8'h21, 1'b0);
        cw(16'h0007); st(8'h21, 1'b0);
        hv_pin = 1'b1;
        // synchroniser plus the shortened settle count
        repeat (30) @(negedge mclk);
        cw(16'h0007); st(8'h23, 1'b0);
        cw(16'h000F); st(8'h27, 1'b1);
        acc(SDSC_FC_RD_HOLD, SDSC_A_POS, 16'h0000);
        acc(SDSC_FC_RD_HOLD, SDSC_A_POS | 16'h0001, 16'h0000);
        `CHK("pos_clr", 16'h0000, r.rdata)
        cw(16'h0007); st(8'h23, 1'b0);
        cw(16'h0006); st(8'h21, 1'b0);
        cw(16'h000F); cw(16'h000F); cw(16'h0006); st(8'h21, 1'b0);
        cw(16'h000F); cw(16'h000F); cw(16'h0000); st(8'h60, 1'b0);
        cw(16'h0006); cw(16'h0007); cw(16'h0002); st(8'h60, 1'b0);
        cw(16'h000F); st(8'h60, 1'b0);
        $display("done t_states");
    endtask

    task automatic t_qstop();
        cw(16'h0006); cw(16'h000F); cw(16'h000F);
        mstop = 1'b0;
        cw(16'h000B); st(8'h07, 1'b1);
        `CHK("moving", 1'b0, stat[SDSC_SW_TREA])
        mstop = 1'b1;
        #1 `CHK("stopped", 1'b1, stat[SDSC_SW_TREA])
        cw(16'h0006); st(8'h07, 1'b1);
        cw(16'h000F); st(8'h27, 1'b1);
        cw(16'h000B); cw(16'h0000); st(8'h60, 1'b0);
        $display("done t_qstop");
    endtask

    task automatic t_fault();
        cw(16'h0006); cw(16'h000F); cw(16'h000F);
        flt_pin = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK("fault", 8'h08, stat[7:0] & 8'h4F)
        `CHK("fault_wind", 1'b0, won)
        cw(16'h0000); cw(16'h0080);
        `CHK("fault_held", 8'h08, stat[7:0] & 8'h4F)
        flt_pin = 1'b0;
        repeat (4) @(negedge mclk);
        cw(16'h0000); cw(16'h0080); st(8'h60, 1'b0);
        $display("done t_fault");
    endtask

    initial begin
        rst_n = 1'b0;
        hv_pin = 1'b0;
        flt_pin = 1'b0;
        mstop = 1'b1;
        step = 1'b0;
        dir = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_pairs();
        t_codes();
        t_states();
        t_qstop();
        t_fault();
        wrap_up();
    end

    // whole run needs about 150 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        wrap_up();
    end
endmodule
